// ### core/ipcb_bank.sv
// Priority and subpriority bank for ten interrupt sources in twelve slots
// Assumes a same-clock register master and a downstream arbiter
`timescale 1ns/10ps
`include "ipcb_cfg.svh"
module ipcb_bank (
   input  wire logic               CLOCK,
   input  wire logic               RST,
   input  wire logic               CLK_EN,
   input  wire ipcb_pkg::ipcb_req_t REQ,
   output logic [31:0]             RDATA,
   output ipcb_pkg::ipcb_bank_t    FIELDS,
   output logic [`IPCB_NSRC-1:0]   SRC_ENABLED
);
   import ipcb_pkg::*;

   // ----------------------------------------------------------------
   // Source slots: index = reg*4 + (3 - lane), lane 3 is the top byte
   // Slot 0/1 (register six lanes 3/2) belong to neighbouring logic
   // ----------------------------------------------------------------
   localparam logic [`IPCB_NSRC-1:0] IMPL = `IPCB_IMPL_MASK;

   ipcb_field_t field_r [`IPCB_NSRC];
   logic [1:0]  sel_reg;
   logic        sel_hit;

   always_comb begin
      sel_hit = 1'b1;
      sel_reg = 2'd0;
      unique case (REQ.addr)
         `IPCB_OFF_SIX   : sel_reg = 2'd0;
         `IPCB_OFF_SEVEN : sel_reg = 2'd1;
         `IPCB_OFF_EIGHT : sel_reg = 2'd2;
         default         : sel_hit = 1'b0;
      endcase
   end

   // ----------------------------------------------------------------
   // Field storage
   // ----------------------------------------------------------------
   genvar g;
   generate
      for (g = 0; g < `IPCB_NSRC; g++) begin : g_fld
         // Lane placement of every source
         localparam int LO = (`IPCB_LANES - 1 - (g % `IPCB_LANES)) * `IPCB_LANE_W;
         if (IMPL[g]) begin : g_impl
            always_ff @(posedge CLOCK or posedge RST) begin
               if (RST) begin
                  field_r[g] <= `IPCB_FIELD_RST;
               end else if (CLK_EN && REQ.wr && sel_hit && sel_reg == 2'(g / 4)) begin
                  // Reserved bits above the field are dropped
                  field_r[g] <= REQ.wdata[LO +: `IPCB_FIELD_W];
               end
            end
         end else begin : g_none
            // Neighbouring slot: held at zero, never written
            always_ff @(posedge CLOCK or posedge RST) begin
               if (RST) begin
                  field_r[g] <= `IPCB_FIELD_RST;
               end
            end
         end
         // Zero priority masks the source
         assign FIELDS[g]      = field_r[g];
         assign SRC_ENABLED[g] = IMPL[g] && (field_r[g].prio != `IPCB_PRIO_OFF);
      end
   endgenerate

   // Layout: prio at lane bits 4..2, subprio at 1..0 of each byte lane

   // ----------------------------------------------------------------
   // Read path
   // ----------------------------------------------------------------
   logic [31:0] reg_word [`IPCB_NREG];
   logic [31:0] rd_word;

   genvar r, l;
   generate
      for (r = 0; r < `IPCB_NREG; r++) begin : g_word
         for (l = 0; l < `IPCB_LANES; l++) begin : g_lane
            localparam int SLOT = r * `IPCB_LANES + (`IPCB_LANES - 1 - l);
            // Reserved lane bits read back as zero
            assign reg_word[r][l*`IPCB_LANE_W +: `IPCB_LANE_W] =
               {{(`IPCB_LANE_W - `IPCB_FIELD_W){1'b0}}, field_r[SLOT]};
         end
      end
   endgenerate

   always_comb begin
      rd_word = 32'h0000_0000;
      if (sel_hit) begin
         rd_word = reg_word[sel_reg];
      end
   end

   always_ff @(posedge CLOCK or posedge RST) begin
      if (RST) begin
         RDATA <= 32'h0000_0000;
      end else if (CLK_EN && REQ.rd) begin
         RDATA <= rd_word;
      end
   end

   // ----------------------------------------------------------------
   // Checks
   // ----------------------------------------------------------------
   a_zero_disables : assert property (@(posedge CLOCK) disable iff (RST)
      (FIELDS[4].prio == 3'h0) |-> !SRC_ENABLED[4])
      else $error("zero priority source enabled");
   a_write_lands : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_SEVEN)
      |=> (FIELDS[4] == $past(REQ.wdata[28:24])))
      else $error("second synchronous field not written");
   a_clockmon_lane : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_EIGHT)
      |=> (FIELDS[9] == $past(REQ.wdata[20:16])))
      else $error("clock monitor field misplaced");
   a_serial_one : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_SIX)
      |=> (FIELDS[3] == $past(REQ.wdata[4:0])))
      else $error("first serial field not written");
   a_readback_six : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_SIX)
      |=> (RDATA[12:8] == $past(FIELDS[2]) && RDATA[31:13] == 19'h0))
      else $error("register six readback wrong");
   a_readback_eight : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_EIGHT)
      |=> (RDATA[4:0] == $past(FIELDS[11]) && RDATA[28:24] == $past(FIELDS[8])))
      else $error("register eight readback wrong");
   a_hold_no_write : assert property (@(posedge CLOCK) disable iff (RST)
      !(CLK_EN && REQ.wr) |=> $stable(FIELDS))
      else $error("field changed without write");
   a_enable_level : assert property (@(posedge CLOCK) disable iff (RST)
      (FIELDS[6].prio == 3'h7) |-> SRC_ENABLED[6])
      else $error("top priority source not enabled");
   a_neighbour_off : assert property (@(posedge CLOCK) disable iff (RST)
      !SRC_ENABLED[0] && !SRC_ENABLED[1])
      else $error("absent slot enabled");

   a_neighbour_zero : assert property (@(posedge CLOCK) disable iff (RST)
      (FIELDS[0] == 5'h00) && (FIELDS[1] == 5'h00))
      else $error("absent slot holds a value");

   a_reset_clear : assert property (@(posedge CLOCK) disable iff (RST)
      $fell(RST) |-> (FIELDS == '0) && (RDATA == 32'h0000_0000))
      else $error("state not cleared by reset");

   // ----------------------------------------------------------------
   // Placement checks
   // ----------------------------------------------------------------
   a_twowire_one_write : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_SIX)
      |=> (FIELDS[2] == $past(REQ.wdata[12:8])))
      else $error("first two-wire field not written");

   a_comp_two_write : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_SEVEN)
      |=> (FIELDS[5] == $past(REQ.wdata[20:16])))
      else $error("second comparator field not written");

   a_comp_one_write : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_SEVEN)
      |=> (FIELDS[6] == $past(REQ.wdata[12:8])))
      else $error("first comparator field not written");

   a_parallel_write : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_SEVEN)
      |=> (FIELDS[7] == $past(REQ.wdata[4:0])))
      else $error("parallel port field not written");

   a_calendar_write : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_EIGHT)
      |=> (FIELDS[8] == $past(REQ.wdata[28:24])))
      else $error("calendar clock field not written");

   a_twowire_two_write : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_EIGHT)
      |=> (FIELDS[10] == $past(REQ.wdata[12:8])))
      else $error("second two-wire field not written");

   a_serial_two_write : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_EIGHT)
      |=> (FIELDS[11] == $past(REQ.wdata[4:0])))
      else $error("second serial field not written");

   a_serial_one_read : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_SIX)
      |=> (RDATA[4:0] == $past(FIELDS[3])))
      else $error("first serial readback wrong");

   a_sync_two_read : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_SEVEN)
      |=> (RDATA[28:24] == $past(FIELDS[4])))
      else $error("second synchronous readback wrong");

   a_comp_two_read : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_SEVEN)
      |=> (RDATA[20:16] == $past(FIELDS[5])))
      else $error("second comparator readback wrong");

   a_comp_one_read : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_SEVEN)
      |=> (RDATA[12:8] == $past(FIELDS[6])))
      else $error("first comparator readback wrong");

   a_parallel_read : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_SEVEN)
      |=> (RDATA[4:0] == $past(FIELDS[7])))
      else $error("parallel port readback wrong");

   a_clockmon_read : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_EIGHT)
      |=> (RDATA[20:16] == $past(FIELDS[9])))
      else $error("clock monitor readback wrong");

   a_twowire_two_read : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_EIGHT)
      |=> (RDATA[12:8] == $past(FIELDS[10])))
      else $error("second two-wire readback wrong");

   a_read_after_write : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr == `IPCB_OFF_SEVEN)
      ##1 (CLK_EN && REQ.rd && REQ.addr == `IPCB_OFF_SEVEN)
      |=> (RDATA == ($past(REQ.wdata, 2) & ~`IPCB_RSVD_MASK)))
      else $error("register seven readback differs from write");

   // ----------------------------------------------------------------
   // Bus and enable checks
   // ----------------------------------------------------------------
   a_freeze_fields : assert property (@(posedge CLOCK) disable iff (RST)
      !CLK_EN |=> $stable(FIELDS))
      else $error("fields changed while frozen");

   a_freeze_rdata : assert property (@(posedge CLOCK) disable iff (RST)
      !CLK_EN |=> $stable(RDATA))
      else $error("read data changed while frozen");

   a_rdata_holds : assert property (@(posedge CLOCK) disable iff (RST)
      !(CLK_EN && REQ.rd) |=> $stable(RDATA))
      else $error("read data changed without read");

   a_unmapped_read : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd && REQ.addr != `IPCB_OFF_SIX && REQ.addr != `IPCB_OFF_SEVEN
       && REQ.addr != `IPCB_OFF_EIGHT) |=> (RDATA == 32'h0000_0000))
      else $error("unmapped read not zero");

   a_unmapped_write : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.wr && REQ.addr != `IPCB_OFF_SIX && REQ.addr != `IPCB_OFF_SEVEN
       && REQ.addr != `IPCB_OFF_EIGHT) |=> $stable(FIELDS))
      else $error("unmapped write changed a field");

   a_reserved_zero : assert property (@(posedge CLOCK) disable iff (RST)
      (CLK_EN && REQ.rd) |=> ((RDATA & `IPCB_RSVD_MASK) == 32'h0000_0000))
      else $error("reserved bits read nonzero");

   a_subprio_no_enable : assert property (@(posedge CLOCK) disable iff (RST)
      (FIELDS[10].prio == 3'h0 && FIELDS[10].subprio != 2'h0) |-> !SRC_ENABLED[10])
      else $error("subpriority alone enabled a source");

   a_low_level : assert property (@(posedge CLOCK) disable iff (RST)
      (FIELDS[8].prio == 3'h1) |-> SRC_ENABLED[8])
      else $error("lowest priority source not enabled");

   a_comp_zero_off : assert property (@(posedge CLOCK) disable iff (RST)
      (FIELDS[6].prio == 3'h0) |-> !SRC_ENABLED[6])
      else $error("comparator enabled at priority zero");

   // ----------------------------------------------------------------
   // Per-slot checks
   // ----------------------------------------------------------------
   generate
      for (g = 0; g < `IPCB_NSRC; g++) begin : g_chk
         localparam logic [`IPCB_ADDR_W-1:0] OFF = (g < `IPCB_LANES) ? `IPCB_OFF_SIX :
            (g < 2 * `IPCB_LANES) ? `IPCB_OFF_SEVEN : `IPCB_OFF_EIGHT;

         a_slot_enable : assert property (@(posedge CLOCK) disable iff (RST)
            SRC_ENABLED[g] == (IMPL[g] && (FIELDS[g].prio != 3'h0)))
            else $error("source enable disagrees with priority");

         a_slot_hold : assert property (@(posedge CLOCK) disable iff (RST)
            !(CLK_EN && REQ.wr && REQ.addr == OFF) |=> $stable(FIELDS[g]))
            else $error("slot changed without its own write");
      end
   endgenerate
endmodule : ipcb_bank

// ### core/ipcb_cfg.svh
// Register offsets, field positions and reset values of the priority bank
// Assumes inclusion by ipcb_pkg and the bank module only
`ifndef IPCB_CFG_SVH
`define IPCB_CFG_SVH
`define IPCB_ADDR_W        4
`define IPCB_OFF_SIX       4'h0
`define IPCB_OFF_SEVEN     4'h4
`define IPCB_OFF_EIGHT     4'h8
`define IPCB_FIELD_RST     5'h00
`define IPCB_PRIO_OFF      3'h0
`define IPCB_LANE3_LO      24
`define IPCB_LANE2_LO      16
`define IPCB_LANE1_LO      8
`define IPCB_LANE0_LO      0
`define IPCB_SUB_LO        0
`define IPCB_PRIO_LO       2
`define IPCB_FIELD_W       5
`define IPCB_NSRC          12
`define IPCB_NREG          3
`define IPCB_LANES         4
`define IPCB_LANE_W        8
`define IPCB_IMPL_MASK     12'hFFC
`define IPCB_RSVD_MASK     32'hE0E0_E0E0
`endif

// ### core/ipcb_pkg.sv
// Types shared by the priority bank and its users
// Assumes ipcb_cfg.svh sits beside it
`include "ipcb_cfg.svh"
package ipcb_pkg;
   typedef struct packed {
      logic [2:0] prio;
      logic [1:0] subprio;
   } ipcb_field_t;
   typedef ipcb_field_t [`IPCB_NSRC-1:0] ipcb_bank_t;
   typedef struct packed {
      logic [`IPCB_ADDR_W-1:0] addr;
      logic [31:0]             wdata;
      logic                    wr;
      logic                    rd;
   } ipcb_req_t;
endpackage : ipcb_pkg

// ### dv/tb_top.sv
// Self-checking bench for the priority bank
// Assumes ipcb_pkg and ipcb_bank are compiled first
`timescale 1ns/10ps
module tb_top;
   import ipcb_pkg::*;
   logic        CLOCK = 1'b0, RST = 1'b1, CLK_EN = 1'b1, rd_d = 1'b0;
   ipcb_req_t   REQ = '0;
   logic [31:0] RDATA, exp_q[$], mdl[3] = '{default: '0};
   logic [31:0] mask[3] = '{32'h0000_1F1F, 32'h1F1F_1F1F, 32'h1F1F_1F1F};
   ipcb_bank_t  FIELDS;
   logic [11:0] SRC_ENABLED;
   logic [15:0] lfsr = 16'h2D24;
   int          fails = 0, comparisons = 0;
   ipcb_bank uut (.CLOCK(CLOCK), .RST(RST), .CLK_EN(CLK_EN), .REQ(REQ), .RDATA(RDATA),
      .FIELDS(FIELDS), .SRC_ENABLED(SRC_ENABLED));
   always #5 CLOCK = ~CLOCK;
   function automatic logic [15:0] lfsr_next(logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction : lfsr_next
   function automatic logic [59:0] exp_fields(logic en);
      logic [59:0] f = '0;
      for (int s = 2; s < 12; s++) begin
         if (en) f[s] = |mdl[s/4][(3-s%4)*8+2 +: 3];
         else f[s*5 +: 5] = mdl[s/4][(3-s%4)*8 +: 5];
      end
      return f;
   endfunction : exp_fields
   task automatic check(string what, logic [59:0] exp, logic [59:0] got);
      comparisons++;
      if (got !== exp) begin
         fails++;
         $display("[FAIL] %s expected %h seen %h", what, exp, got);
      end
   endtask : check
   task automatic wr(logic [3:0] a, logic [31:0] d, logic en);
      REQ <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      CLK_EN <= en;
      if (en && a < 4'hC) mdl[a[3:2]] = d & mask[a[3:2]];
      @(posedge CLOCK);
   endtask : wr
   task automatic rd(logic [3:0] a);
      REQ <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      CLK_EN <= 1'b1;
      exp_q.push_back(a < 4'hC ? mdl[a[3:2]] : 32'h0);
      @(posedge CLOCK);
   endtask : rd
   task automatic conclude();
      if (fails == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask : conclude
   // Read results land one cycle after the strobe
   always @(posedge CLOCK) rd_d <= REQ.rd & CLK_EN & ~RST;
   always @(negedge CLOCK) begin
      if (rd_d) check("RDATA", exp_q.pop_front(), RDATA);
   end
   // ----------------
   // Stimulus
   // ----------------
   initial begin
      logic [31:0] d;
      repeat (16) @(posedge CLOCK);
      RST <= 1'b0;
      @(posedge CLOCK);
      for (int a = 0; a < 16; a += 4) rd(4'(a));
      for (int n = 0; n < 28; n++) begin
         lfsr = lfsr_next(lfsr);
         d = n < 4 ? 32'h1F1F_1F1F : n > 23 ? 32'h0 : {lfsr, lfsr_next(lfsr)};
         wr(4'(n % 4 * 4), d & 32'h1F1F_1F1F, 1'b1);
         rd(4'(n % 4 * 4));
         #1 check("FIELDS", exp_fields(1'b0), FIELDS);
         check("FIELDS", exp_fields(1'b0), FIELDS);
         check("FIELDS", exp_fields(1'b0), FIELDS);
         check("SRC_ENABLED", exp_fields(1'b1), 60'(SRC_ENABLED));
         if (n == 19) begin
            wr(4'h4, 32'h0303_0303, 1'b0);
            rd(4'h4);
         end
      end
      REQ <= '0;
      repeat (2) @(posedge CLOCK);
      check("pending", 60'h0, 60'(exp_q.size()));
      wr(4'h8, 32'h1F1F_1F1F, 1'b1);
      RST <= 1'b1;
      #1 check("FIELDS", 60'h0, FIELDS);
      check("RDATA", 60'h0, 60'(RDATA));
      conclude();
   end
endmodule : tb_top
